// *** verilog/fct_top.v ***
/*
  Four-channel 8-bit counter/timer with byte-wide I/O port and interrupt
  daisy chain. Assumes a host bus synchronous to CLK; data bus is split
  into input, output and output enable.
*/
`include "fct_map.vh"

module fct_top (
  // clock and reset
  input  wire       CLK,
  input  wire       NRST,
  // host bus
  input  wire       CHIP_EN_N,
  input  wire       CHAN_SEL_LO,
  input  wire       CHAN_SEL_HI,
  input  wire       IO_REQUEST_N,
  input  wire       READ_N,
  input  wire       OPCODE_FETCH_N,
  input  wire [7:0] D_IN,
  output reg  [7:0] D_OUT,
  output reg        D_OE,
  // daisy chain
  input  wire       CHAIN_ENABLE_IN,
  output wire       CHAIN_ENABLE_OUT,
  output wire       INT_N,
  output wire       INT_OE,
  // channel pins
  input  wire [3:0] EXT_COUNT_TRIGGER,
  output wire [2:0] ZERO_COUNT_PULSE
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // channel select
  wire [1:0] sel = {CHAN_SEL_HI, CHAN_SEL_LO};
  wire       acc = ~CHIP_EN_N & ~IO_REQUEST_N & OPCODE_FETCH_N;
  wire       inta = ~IO_REQUEST_N & ~OPCODE_FETCH_N;
  reg        acc_q;
  // one write per I/O cycle: take it on the leading cycle only
  wire       wr_stb = acc & READ_N & ~acc_q;
  wire [3:0] tc_pend;
  wire [3:0] ie;
  wire [3:0] zero;
  wire [31:0] counts;
  reg  [4:0] vec_q;
  reg  [3:0] ip_q;
  reg  [3:0] ius_q;
  reg  [1:0] s1_q [0:3];

  always @(posedge CLK)
  begin
    if (!NRST)
      acc_q <= 1'b0;
    else
      acc_q <= acc;
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      localparam [1:0] CH_ID = g;
      wire sel_me = wr_stb & (sel == CH_ID);
      // bit 0 set is control; pending constant takes priority
      wire cw_we  = sel_me & ~tc_pend[g] & D_IN[`FCT_CW_CTRL];
      wire tc_we  = sel_me & tc_pend[g];
      always @(posedge CLK)
      begin
        s1_q[g] <= {s1_q[g][0], EXT_COUNT_TRIGGER[g]};
      end
      fct_channel u_ch (
        .CLK       (CLK),
        .NRST      (NRST),
        .CW_WE     (cw_we),
        .TC_WE     (tc_we),
        .WDATA     (D_IN),
        .TRIG_SYNC (s1_q[g][1]),
        .COUNT     (counts[8*g +: 8]),
        .TC_PEND   (tc_pend[g]),
        .IE        (ie[g]),
        .ZERO      (zero[g])
      );
    end
  endgenerate

  assign ZERO_COUNT_PULSE = zero[2:0];

  // ----------------------------------------------------------------
  // vector and interrupt state
  // ----------------------------------------------------------------
  wire [3:0] pend = ip_q & ~ius_q;
  reg  [1:0] top_ch;
  reg        top_any;
  integer    i;
  always @*
  begin
    top_ch  = 2'h0;
    top_any = 1'b0;
    for (i = 3; i >= 0; i = i - 1)
      if (pend[i])
      begin
        top_ch  = i[1:0];
        top_any = 1'b1;
      end
  end

  reg inta_q;
  always @(posedge CLK)
  begin
    if (!NRST)
    begin
      vec_q  <= `FCT_VEC_RESET;
      ip_q   <= 4'h0;
      ius_q  <= 4'h0;
      inta_q <= 1'b0;
    end
    else
    begin
      inta_q <= inta;
      // vector via channel 0, bit 0 clear
      if (wr_stb && sel == 2'h0 && !tc_pend[0] && !D_IN[`FCT_CW_CTRL])
        vec_q <= D_IN[7:3];
      // zero count raises request when enabled; set beats clear
      ip_q <= (ip_q & ie) | (zero & ie);
      // acknowledge moves top request into service
      if (inta && !inta_q && CHAIN_ENABLE_IN && top_any)
      begin
        ip_q[top_ch]  <= zero[top_ch] & ie[top_ch];
        ius_q[top_ch] <= 1'b1;
      end
      // service ends on any later host write to that channel's select, except a constant write to channel 0
      if (wr_stb && sel != 2'h0)
        ius_q[sel] <= 1'b0;
      else if (wr_stb && sel == 2'h0 && !tc_pend[0])
        ius_q[0] <= 1'b0;
    end
  end

  assign CHAIN_ENABLE_OUT = CHAIN_ENABLE_IN & (ius_q == 4'h0) & (ip_q == 4'h0);
  assign INT_N  = 1'b0;
  assign INT_OE = |pend & CHAIN_ENABLE_IN;

  // ----------------------------------------------------------------
  // read data and vector drive
  // ----------------------------------------------------------------
  always @(posedge CLK)
  begin
    if (!NRST)
    begin
      D_OUT <= 8'h00;
      D_OE  <= 1'b0;
    end
    else if (inta && inta_q && CHAIN_ENABLE_IN && D_OE)
    begin
      // vector stands for the whole acknowledge
      // the winner has already moved into service, so keep the captured byte
      D_OUT <= D_OUT;
      D_OE  <= 1'b1;
    end
    else if (inta && !inta_q && CHAIN_ENABLE_IN && top_any)
    begin
      D_OUT <= {vec_q, top_ch, 1'b0};
      D_OE  <= 1'b1;
    end
    else if (acc && !READ_N)
    begin
      D_OUT <= counts[8*sel +: 8];
      D_OE  <= 1'b1;
    end
    else
    begin
      D_OUT <= 8'h00;
      D_OE  <= 1'b0;
    end
  end

endmodule // fct_top

// *** verilog/fct_map.vh ***
/*
  Constants for the four-channel counter/timer: control word fields,
  prescaler counts, automatic start delay and reset values.
  Assumes inclusion by bare name from the design files under verilog/.
*/
// Function
// - written word with bit 0 set is a control word; else channel 0 vector
// - control word with bit 2 set makes next write the time constant
// - channel idle until a constant arrives; bit 2 clear only updates settings
// - new constant during counting loads only at the next zero count
// - time constant zero counts as 256
// - two-bit select picks channel 0..3 for reads and writes
// - vector upper five bits stored; bits 2:1 channel; bit 0 zero
// - hardware reset stops counting, clears enables, outputs idle, bus floats
// - bit 1 stops channel, updates control, needs new constant
// - bits 1 and 2 together halt until constant written, then resume
// - bit 7 enables zero-count interrupt; may change any time
// - bit 6 timer or counter; bit 5 prescaler 16 or 256
// - bit 4 picks trigger edge; changing it acts as an active edge
// - automatic timer starts on second clock of next machine cycle
// - triggered timer first decrement one clock after synchronised edge; the code decrements only after a full prescale
// - running timer reloads at zero and continues without gap
// - timer period is clock times prescaler times constant
// - counter mode edge decrements; timer mode edge starts timer
// - selected chip takes writes and returns down-counter on reads
// - channels 0..2 pulse zero-count output high at zero
// - on acknowledge with chain input high, top requester drives vector
`ifndef FCT_MAP_VH
`define FCT_MAP_VH

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define FCT_CW_CTRL      0
`define FCT_CW_SWRST     1
`define FCT_CW_TCF       2
`define FCT_CW_TRIG      3
`define FCT_CW_SLOPE     4
`define FCT_CW_PRE       5
`define FCT_CW_MODE      6
`define FCT_CW_IE        7
`define FCT_CW_RESET     8'h00

// ----------------------------------------------------------------
// vector and timing
// ----------------------------------------------------------------
`define FCT_VEC_RESET    5'h00
`define FCT_PRE16_LAST   8'h0F
`define FCT_PRE256_LAST  8'hFF
`define FCT_AUTO_DELAY   3'h2

`endif

// *** verilog/fct_channel.v ***
/*
  One counter/timer channel: control register, time constant, prescaler,
  down-counter and zero-count event. Assumes the top decodes bus writes
  and supplies a synchronised trigger level.
*/
`include "fct_map.vh"

module fct_channel (
  // clock and reset
  input  wire       CLK,
  input  wire       NRST,
  // host writes
  input  wire       CW_WE,
  input  wire       TC_WE,
  input  wire [7:0] WDATA,
  // synchronised trigger level
  input  wire       TRIG_SYNC,
  // status
  output wire [7:0] COUNT,
  output wire       TC_PEND,
  output wire       IE,
  output reg        ZERO
);

  reg  [7:0] ctrl_q;
  reg  [7:0] tc_q;
  reg  [7:0] cnt_q;
  reg  [7:0] pre_q;
  reg        run_q;
  reg        armed_q;
  reg        tcf_q;
  reg        trig_q;
  reg  [2:0] dly_q;

  wire       timer_mode = ctrl_q[`FCT_CW_MODE];
  wire [7:0] pre_last   = ctrl_q[`FCT_CW_PRE] ? `FCT_PRE256_LAST : `FCT_PRE16_LAST;
  // selected edge seen on the synchronised trigger
  wire       lvl_edge   = ctrl_q[`FCT_CW_SLOPE] ? (TRIG_SYNC & ~trig_q)
                                                : (~TRIG_SYNC & trig_q);
  // slope change acts as an edge
  wire       slope_chg  = CW_WE & (WDATA[`FCT_CW_SLOPE] != ctrl_q[`FCT_CW_SLOPE]);
  wire       act_edge   = lvl_edge | slope_chg;
  wire       tick       = timer_mode ? (run_q & (pre_q == pre_last)) : (run_q & act_edge);

  assign COUNT   = cnt_q;
  assign TC_PEND = tcf_q;
  assign IE      = ctrl_q[`FCT_CW_IE];

  // channel state; control write is taken before constant pending check
  always @(posedge CLK)
  begin
    ZERO   <= 1'b0;
    trig_q <= TRIG_SYNC;
    if (!NRST)
    begin
      ctrl_q  <= `FCT_CW_RESET;
      tc_q    <= 8'h00;
      cnt_q   <= 8'h00;
      pre_q   <= 8'h00;
      run_q   <= 1'b0;
      armed_q <= 1'b0;
      tcf_q   <= 1'b0;
      dly_q   <= 3'h0;
    end
    else
    begin
      if (CW_WE)
      begin
        ctrl_q <= WDATA;
        tcf_q  <= WDATA[`FCT_CW_TCF];
        if (WDATA[`FCT_CW_SWRST])
        begin
          run_q   <= 1'b0;
          armed_q <= 1'b0;
          dly_q   <= 3'h0;
        end
      end
      else if (TC_WE)
      begin
        tcf_q <= 1'b0;
        tc_q  <= WDATA;
        // running channel keeps count, reloads later
        if (!run_q && !armed_q)
        begin
          cnt_q <= WDATA;
          pre_q <= 8'h00;
          if (!timer_mode)
            run_q <= 1'b1;
          else if (!ctrl_q[`FCT_CW_TRIG])
            dly_q <= `FCT_AUTO_DELAY;
          else
            armed_q <= 1'b1;
        end
      end
      // automatic start countdown
      if (dly_q != 3'h0 && !(CW_WE && WDATA[`FCT_CW_SWRST]))
      begin
        dly_q <= dly_q - 3'h1;
        if (dly_q == 3'h1)
          run_q <= 1'b1;
      end
      if (armed_q && act_edge && !(CW_WE && WDATA[`FCT_CW_SWRST]))
      begin
        armed_q <= 1'b0;
        run_q   <= 1'b1;
      end
      // prescaler divides by 16 or 256
      if (run_q && timer_mode)
        pre_q <= (pre_q == pre_last) ? 8'h00 : pre_q + 8'h01;
      if (tick && !(CW_WE && WDATA[`FCT_CW_SWRST]))
      begin
        // zero constant gives 256 via wrap
        if (cnt_q == 8'h01)
        begin
          cnt_q <= tc_q;
          ZERO  <= 1'b1;
        end
        else
          cnt_q <= cnt_q - 8'h01;
      end
    end
  end

endmodule // fct_channel

// *** dv/fct_monitor.sv ***
/*
  Port checker for fct_top.
  Assumes a bind to every fct_top and a synchronous active-low reset.
*/
module fct_monitor (
  // watched ports
  input wire       CLK,
  input wire       NRST,
  input wire       CHIP_EN_N,
  input wire       IO_REQUEST_N,
  input wire       READ_N,
  input wire       OPCODE_FETCH_N,
  input wire [7:0] D_OUT,
  input wire       D_OE,
  input wire       CHAIN_ENABLE_IN,
  input wire       CHAIN_ENABLE_OUT,
  input wire       INT_OE,
  input wire [2:0] ZERO_COUNT_PULSE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!NRST);
  // decoded bus cycles
  wire rd_acc = !CHIP_EN_N && !IO_REQUEST_N && !READ_N && OPCODE_FETCH_N;
  wire wr_acc = !CHIP_EN_N && !IO_REQUEST_N && READ_N && OPCODE_FETCH_N;
  wire ack    = !IO_REQUEST_N && !OPCODE_FETCH_N;
  read_drive_a: assert property (rd_acc |=> D_OE) else $error("read not driven");
  write_quiet_a: assert property (wr_acc |=> !D_OE) else $error("drive on write");
  idle_float_a: assert property (IO_REQUEST_N |=> !D_OE) else $error("bus not freed");
  ack_blocked_a: assert property (ack && !CHAIN_ENABLE_IN |=> !D_OE)
    else $error("vector without priority");
  vec_even_a: assert property (ack && CHAIN_ENABLE_IN ##1 D_OE |-> !D_OUT[0])
    else $error("vector bit 0 set");
  chain_low_a: assert property (!CHAIN_ENABLE_IN |-> !CHAIN_ENABLE_OUT)
    else $error("chain out high");
  int_block_a: assert property (INT_OE |-> !CHAIN_ENABLE_OUT)
    else $error("pending request not blocking chain");
  pulse_once_a: assert property ((ZERO_COUNT_PULSE & $past(ZERO_COUNT_PULSE)) == 3'h0)
    else $error("zero pulse longer than one clock");
endmodule // fct_monitor

bind fct_top fct_monitor u_mon (.CLK, .NRST, .CHIP_EN_N, .IO_REQUEST_N, .READ_N,
  .OPCODE_FETCH_N, .D_OUT, .D_OE, .CHAIN_ENABLE_IN, .CHAIN_ENABLE_OUT, .INT_OE,
  .ZERO_COUNT_PULSE);

// *** dv/fct_trig_src.sv ***
/*
  External event source for the four trigger lines.
  Assumes one request at a time, at least seven clocks apart.
*/
module fct_trig_src (
  // clock
  input  wire       clk,
  // request and trigger lines
  input  wire [3:0] fire,
  output reg  [3:0] trig_q
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [1:0] hold_q = 2'h0;
  initial trig_q = 4'h0;
  // held three clocks so the two-flop synchroniser cannot miss it
  always @(posedge clk)
  begin
    if (fire != 4'h0)
    begin
      trig_q <= fire;
      hold_q <= 2'h3;
    end
    else if (hold_q != 2'h0)
    begin
      hold_q <= hold_q - 2'h1;
      if (hold_q == 2'h1)
        trig_q <= 4'h0;
    end
  end
endmodule // fct_trig_src

// *** dv/fct_tb_top.sv ***
/*
  Self-checking bench for fct_top with a behavioural count model.
  Assumes fct_monitor is bound and fct_trig_src drives the triggers.
*/
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module fct_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLK = 0, NRST = 0, CHIP_EN_N = 1, SEL_LO = 0, SEL_HI = 0;
  logic       IO_REQUEST_N = 1, READ_N = 1, OPCODE_FETCH_N = 1, CHAIN_IN = 1;
  logic [7:0] D_IN = 8'h00, q, lf = 8'h0F;
  logic [3:0] fire = 4'h0, trig;
  wire  [7:0] D_OUT;
  wire  [2:0] zcp;
  wire        D_OE, CHAIN_OUT, INT_OE;
  int         bad_count, num_checks, n, seen[3], zm[3], tcm[4], cnt[4];
  fct_top u_dut (.CLK, .NRST, .CHIP_EN_N, .CHAN_SEL_LO(SEL_LO), .CHAN_SEL_HI(SEL_HI),
    .IO_REQUEST_N, .READ_N, .OPCODE_FETCH_N, .D_IN, .D_OUT, .D_OE,
    .CHAIN_ENABLE_IN(CHAIN_IN), .CHAIN_ENABLE_OUT(CHAIN_OUT), .INT_N(), .INT_OE,
    .EXT_COUNT_TRIGGER(trig), .ZERO_COUNT_PULSE(zcp));
  fct_trig_src u_src (.clk(CLK), .fire(fire), .trig_q(trig));
  // 200 MHz clock
  initial forever #2.5 CLK = ~CLK;
  // count zero pulses per channel
  always @(posedge CLK)
    for (int i = 0; i < 3; i++) if (zcp[i] === 1'b1) seen[i]++;
  function automatic [7:0] lfsr(input [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one whole access: kind 0 write, 1 read, 2 acknowledge
  task automatic acc(input [1:0] ch, input [1:0] kind, input [7:0] d);
    @(posedge CLK);
    {SEL_HI, SEL_LO} <= ch;
    CHIP_EN_N <= (kind == 2);
    IO_REQUEST_N <= 0;
    READ_N <= (kind != 1);
    OPCODE_FETCH_N <= (kind != 2);
    D_IN <= d;
    repeat (2) @(posedge CLK);
    #1 q = D_OUT;
    @(posedge CLK);
    {CHIP_EN_N, IO_REQUEST_N, READ_N, OPCODE_FETCH_N} <= 4'hF;
  endtask
  // control word with bit 2 set first, then constant
  task automatic prog(input [1:0] ch, input [7:0] cw, input [7:0] tc, input bit fresh);
    acc(ch, 0, cw);
    acc(ch, 0, tc);
    tcm[ch] = (tc == 0) ? 256 : tc;
    if (fresh) cnt[ch] = tcm[ch];
  endtask
  // one rising trigger edge; model decrements and reloads at zero
  task automatic edge_on(input [1:0] ch);
    @(posedge CLK);
    fire[ch] <= 1'b1;
    @(posedge CLK);
    fire <= 4'h0;
    repeat (6) @(posedge CLK);
    cnt[ch]--;
    if (cnt[ch] == 0) begin cnt[ch] = tcm[ch]; if (ch < 3) zm[ch]++; end
  endtask
  task automatic rd_chk(input [1:0] ch);
    acc(ch, 1, 8'h00);
    `CHK(q, cnt[ch][7:0])
  endtask
  task automatic wait_pulse;
    n = 0;
    do begin @(posedge CLK); n++; end while (zcp[0] !== 1'b1 && n < 600);
    if (n >= 600) begin bad_count++; end_of_test(); end
  endtask
  // mode bit 6 set selects timer, clear selects counter
  initial begin
    repeat (5) @(posedge CLK);
    `CHK({D_OE, zcp, INT_OE, CHAIN_OUT}, 6'h01)
    NRST <= 1;
    // every channel reprogrammed after reset: counter, random constant
    for (int ch = 0; ch < 4; ch++) begin
      lf = lfsr(lf);
      prog(ch, 8'h15, lf % 5 + 2, 1);
      for (int e = 0; e <= tcm[ch]; e++) begin edge_on(ch); rd_chk(ch); end
      if (ch < 3) `CHK(seen[ch], zm[ch])
    end
    // reprogram while counting: new constant only after zero
    prog(3, 8'h15, 8'h05, 0);
    rd_chk(3);
    while (cnt[3] != 5) edge_on(3);
    rd_chk(3);
    // constant zero behaves as 256; soft reset lets the constant load at once
    prog(2, 8'h17, 8'h00, 1);
    edge_on(2);
    rd_chk(2);
    // software reset freezes the count
    acc(1, 0, 8'h13);
    edge_on(1);
    cnt[1]++;
    rd_chk(1);
    prog(1, 8'h17, 8'h04, 1);
    edge_on(1);
    rd_chk(1);
    // slope change while counting acts as one edge
    acc(1, 0, 8'h05);
    cnt[1]--;
    rd_chk(1);
    // triggered timer holds until its edge, first decrement one prescale later
    prog(3, 8'h5F, 8'h10, 1);
    repeat (40) @(posedge CLK);
    rd_chk(3);
    edge_on(3);
    cnt[3]++;
    rd_chk(3);
    repeat (16) @(posedge CLK);
    cnt[3]--;
    rd_chk(3);
    // automatic timer periods with both prescalers
    for (int k = 0; k < 2; k++) begin
      prog(0, k ? 8'h77 : 8'h57, k ? 8'h01 : 8'h02, 1);
      wait_pulse();
      wait_pulse();
      `CHK(n, k ? 256 : 32)
    end
    // vector base, then interrupt from channel 2
    acc(0, 0, 8'hA8);
    prog(2, 8'h97, 8'h01, 1);
    edge_on(2);
    `CHK(INT_OE, 1'b1)
    CHAIN_IN <= 0;
    acc(0, 2, 8'h00);
    `CHK(q, 8'h00)
    CHAIN_IN <= 1;
    acc(0, 2, 8'h00);
    `CHK(q, 8'hAC)
    end_of_test();
  end
endmodule // fct_tb_top
